// ### design/port_pin_map.svh
// constants for the port pin override logic
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH
`define PP_ADDR_W 4
`define PP_ADR_DIR 4'h0
`define PP_ADR_OUT 4'h1
`define PP_ADR_PIN 4'h2
`define PP_ADR_CTRL 4'h3
`define PP_CTRL_PUD_BIT 0
`define PP_CTRL_SLEEP_BIT 1
`define PP_RST_DIR 8'h00
`define PP_RST_OUT 8'h00
`define PP_RST_CTRL 2'h0
`endif

// ### design/port_pin_override_mux.sv
// one gpio port with peripheral override, sleep clamp and wishbone registers
// Behaviour
// - sleep clamps digital inputs to ground
// - enabled external interrupt pins bypass clamp
// - input enable override bypasses clamp
// - clamp release creates sensed interrupt edge
// - reset switches all pull-ups off
// - pull-up from override or dir/out/pud=010
// - pull-up override ignores register bits
// - driver enable from override or direction
// - direction override ignores direction bit
// - driven level from override or output
// - value override ignores output bit
// - toggle override inverts output bit
// - input enable from override or sleep
// - input enable override ignores sleep state
// - raw tap after schmitt, before synchroniser
// - analog tap wired straight to pad
// - strobes per port, clamp/pud global
// - direction one output, zero input
// - writing pin bit toggles output bit
// - pad passes two stages before pin bit
// - global pull-up off disables register pull-ups, not override ones
`timescale 1ns/10ps
`include "port_pin_map.svh"

module port_pin_override_mux #(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PP_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // sleep controller and external interrupt enables
  input wire logic sleep_clamp,
  input wire logic [WIDTH-1:0] ext_irq_en,
  // peripheral overrides, one per pin
  input wire port_pin_pkg::override_t [WIDTH-1:0] ovr,
  // pad
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_pullup,
  output logic [WIDTH-1:0] input_enable,
  // taps to peripherals
  output logic [WIDTH-1:0] schmitt_tap_to_peripheral,
  input wire logic [WIDTH-1:0] analog_pad_line,
  output logic [WIDTH-1:0] analog_tap
);

  logic [WIDTH-1:0] pin_direction_bit_r, pin_direction_bit_nxt;
  logic [WIDTH-1:0] pin_output_bit_r, pin_output_bit_nxt;
  logic [1:0] mcu_control_reg_r, mcu_control_reg_nxt;
  logic [WIDTH-1:0] sync1_r, sync1_nxt;
  logic [WIDTH-1:0] pin_sampled_bit_r, pin_sampled_bit_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic global_pullup_off;
  logic sleep_sw;
  logic sleep_any;
  logic req;
  logic wr_dir, wr_out, wr_pin, wr_ctrl;
  logic [WIDTH-1:0] toggle_req;
  logic [WIDTH-1:0] wdat;

  assign global_pullup_off = mcu_control_reg_r[`PP_CTRL_PUD_BIT];
  assign sleep_sw = mcu_control_reg_r[`PP_CTRL_SLEEP_BIT];
  // global clamp: external controller or software sleep request
  assign sleep_any = sleep_clamp | sleep_sw;
  assign req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
  assign wdat = wb_dat_i[WIDTH-1:0];
  // shared write strobes per port
  assign wr_dir = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PP_ADR_DIR);
  assign wr_out = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PP_ADR_OUT);
  assign wr_pin = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PP_ADR_PIN);
  assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PP_ADR_CTRL);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic clamp_off;
      logic pullup_g;
      // all override enables low: plain gpio pin
      // toggle from software pin write or peripheral
      assign toggle_req[g] = (wr_pin & wdat[g]) | ovr[g].toggle_override_en;
      // digital input enable
      always_comb begin
        if (ovr[g].input_enable_override_en) begin
          clamp_off = ovr[g].input_enable_override_val;
        end else begin
          clamp_off = ~sleep_any | ext_irq_en[g];
        end
      end
      assign input_enable[g] = clamp_off;
      // clamped pad to ground; release makes a visible edge
      assign schmitt_tap_to_peripheral[g] = pad_in[g] & clamp_off;
      // driver enable
      assign pad_oe[g] = ovr[g].dir_override_en ? ovr[g].dir_override_val
                                                : pin_direction_bit_r[g];
      // driven level
      assign pad_out[g] = ovr[g].value_override_en ? ovr[g].value_override_val
                                                   : pin_output_bit_r[g];
      // pull-up, off under reset
      always_comb begin
        if (!rst_n) begin
          pullup_g = 1'b0;
        end else if (ovr[g].pullup_override_en) begin
          pullup_g = ovr[g].pullup_override_val;
        end else begin
          pullup_g = ~pin_direction_bit_r[g] & pin_output_bit_r[g]
                     & ~global_pullup_off;
        end
      end
      assign pad_pullup[g] = pullup_g;
      assign analog_tap[g] = analog_pad_line[g];
    end
  endgenerate

  // register next values
  always_comb begin
    pin_direction_bit_nxt = pin_direction_bit_r;
    pin_output_bit_nxt = pin_output_bit_r ^ toggle_req;
    mcu_control_reg_nxt = mcu_control_reg_r;
    if (wr_dir) begin
      pin_direction_bit_nxt = wdat;
    end
    if (wr_out) begin
      pin_output_bit_nxt = wdat;
    end
    if (wr_ctrl) begin
      mcu_control_reg_nxt = wb_dat_i[1:0];
    end
  end

  // two stage sampling of the schmitt output
  always_comb begin
    sync1_nxt = schmitt_tap_to_peripheral;
    pin_sampled_bit_nxt = sync1_r;
  end

  // wishbone answer, one cycle after strobe
  always_comb begin
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rdat_nxt = rdat_r;
    if (req) begin
      unique case (wb_adr_i)
        `PP_ADR_DIR: begin
          ack_nxt = 1'b1;
          rdat_nxt = 32'(pin_direction_bit_r);
        end
        `PP_ADR_OUT: begin
          ack_nxt = 1'b1;
          rdat_nxt = 32'(pin_output_bit_r);
        end
        `PP_ADR_PIN: begin
          ack_nxt = 1'b1;
          rdat_nxt = 32'(pin_sampled_bit_r);
        end
        `PP_ADR_CTRL: begin
          ack_nxt = 1'b1;
          rdat_nxt = 32'(mcu_control_reg_r);
        end
        default: begin
          err_nxt = 1'b1;
          rdat_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_bit_r <= WIDTH'(`PP_RST_DIR);
      pin_output_bit_r <= WIDTH'(`PP_RST_OUT);
      mcu_control_reg_r <= `PP_RST_CTRL;
      sync1_r <= '0;
      pin_sampled_bit_r <= '0;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else if (clk_en) begin
      pin_direction_bit_r <= pin_direction_bit_nxt;
      pin_output_bit_r <= pin_output_bit_nxt;
      mcu_control_reg_r <= mcu_control_reg_nxt;
      sync1_r <= sync1_nxt;
      pin_sampled_bit_r <= pin_sampled_bit_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;

  // checks
  logic past_valid_r;
  logic past_valid2_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      past_valid_r <= 1'b0;
      past_valid2_r <= 1'b0;
    end else begin
      past_valid_r <= 1'b1;
      past_valid2_r <= past_valid_r;
    end
  end

  sequence s_pin_write(int b);
    wr_pin && wb_dat_i[b] && clk_en && !ovr[b].toggle_override_en
      && !wr_out;
  endsequence

  // peripheral toggle with no software write to that bit
  sequence s_peri_toggle(int b);
    clk_en && ovr[b].toggle_override_en && !wr_out && !(wr_pin && wb_dat_i[b]);
  endsequence

  // pin held high while clamped, then released
  sequence s_clamp_high(int b);
    sleep_any && !ext_irq_en[b] && !ovr[b].input_enable_override_en && pad_in[b];
  endsequence
  sequence s_awake_high(int b);
    !sleep_any && !ovr[b].input_enable_override_en && pad_in[b];
  endsequence
  sequence s_release(int b);
    s_clamp_high(b) ##1 s_awake_high(b);
  endsequence

  AST_PULLUP_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ovr[0].pullup_override_en && global_pullup_off) |-> !pad_pullup[0])
    else $error("pull-up on while globally off");
  AST_PULLUP_OVR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovr[0].pullup_override_en |-> pad_pullup[0] == ovr[0].pullup_override_val)
    else $error("pull-up ignores override");
  AST_OE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pad_oe[0] == (ovr[0].dir_override_en ? ovr[0].dir_override_val
                                         : pin_direction_bit_r[0]))
    else $error("driver enable wrong source");
  AST_VAL_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovr[0].value_override_en |-> pad_out[0] == ovr[0].value_override_val)
    else $error("pin value ignores override");
  AST_CLAMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleep_any && !ext_irq_en[0] && !ovr[0].input_enable_override_en)
      |-> !schmitt_tap_to_peripheral[0])
    else $error("input not clamped in sleep");
  AST_IRQ_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ext_irq_en[0] && !ovr[0].input_enable_override_en) |-> input_enable[0])
    else $error("interrupt pin clamped");
  AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pin_write(0) |=> pin_output_bit_r[0] != $past(pin_output_bit_r[0]))
    else $error("pin write did not toggle output");
  AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (past_valid2_r && clk_en && $past(clk_en) && $past(clk_en, 2))
      |-> pin_sampled_bit_r == $past(schmitt_tap_to_peripheral, 2))
    else $error("sampled pin not two stages late");
  AST_ACK_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wb_ack_o && clk_en) |=> !wb_ack_o)
    else $error("ack held two cycles");
  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clk_en |=> $stable(pin_output_bit_r) && $stable(pin_direction_bit_r))
    else $error("state moved while clock enable low");
  AST_ERR_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req && clk_en && wb_adr_i > `PP_ADR_CTRL) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");

  // per-pin checks, same for every pin of the port
  generate
    for (g = 0; g < WIDTH; g++) begin : g_chk
      AST_PU_IN_RESET: assert property (@(posedge clk_sys)
        !rst_n |-> !pad_pullup[g])
        else $error("pull-up on during reset");
      AST_PU_GPIO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ovr[g].pullup_override_en |-> pad_pullup[g] == (!pin_direction_bit_r[g]
          && pin_output_bit_r[g] && !global_pullup_off))
        else $error("pull-up not from register bits");
      AST_PU_OVR_ALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovr[g].pullup_override_en |-> pad_pullup[g] == ovr[g].pullup_override_val)
        else $error("pull-up ignores override");
      AST_PU_OUTPUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ovr[g].pullup_override_en && pin_direction_bit_r[g]) |-> !pad_pullup[g])
        else $error("pull-up on an output pin");
      AST_PUD_ALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ovr[g].pullup_override_en && global_pullup_off) |-> !pad_pullup[g])
        else $error("pull-up on while globally off");
      AST_DIR_OVR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovr[g].dir_override_en |-> pad_oe[g] == ovr[g].dir_override_val)
        else $error("driver enable ignores override");
      AST_DIR_REG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ovr[g].dir_override_en |-> pad_oe[g] == pin_direction_bit_r[g])
        else $error("driver enable not from direction bit");
      AST_VAL_REG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pad_oe[g] && !ovr[g].value_override_en) |-> pad_out[g] == pin_output_bit_r[g])
        else $error("driven level not from output bit");
      AST_VAL_OVR_ALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovr[g].value_override_en |-> pad_out[g] == ovr[g].value_override_val)
        else $error("driven level ignores override");
      AST_PERI_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_peri_toggle(g) |=> pin_output_bit_r[g] != $past(pin_output_bit_r[g]))
        else $error("toggle override did not invert output");
      AST_IEN_OVR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovr[g].input_enable_override_en |-> input_enable[g] == ovr[g].input_enable_override_val)
        else $error("input enable ignores override");
      AST_IEN_AWAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ovr[g].input_enable_override_en && !sleep_any) |-> input_enable[g])
        else $error("input disabled while awake");
      AST_IEN_SLEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ovr[g].input_enable_override_en && sleep_any && !ext_irq_en[g]) |-> !input_enable[g])
        else $error("input enabled in sleep");
      AST_IRQ_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ovr[g].input_enable_override_en && ext_irq_en[g]) |-> input_enable[g])
        else $error("interrupt pin clamped");
      AST_TAP_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        schmitt_tap_to_peripheral[g] == (pad_in[g] && input_enable[g]))
        else $error("raw tap not gated pad level");
      AST_RELEASE_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_release(g) |-> $rose(schmitt_tap_to_peripheral[g]))
        else $error("clamp release made no edge");
      AST_ANALOG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        analog_tap[g] == analog_pad_line[g])
        else $error("analog tap not straight");
    end
  endgenerate

endmodule // port_pin_override_mux

// ### design/port_pin_pkg.sv
// types for the port pin override logic
package port_pin_pkg;
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_enable_override_en;
    logic input_enable_override_val;
  } override_t;
endpackage

// ### testbench/pad_model.sv
// pad and external world model for the port pins
`timescale 1ns/10ps
module pad_model #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic clk_sys,
  // design side
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] pad_pullup,
  // external drivers
  input wire logic [WIDTH-1:0] ext_drv,
  input wire logic [WIDTH-1:0] ext_val,
  output logic [WIDTH-1:0] pad_level
);
  logic [WIDTH-1:0] float_r = '0;
  // undriven line without pull-up wanders every cycle
  always @(posedge clk_sys) float_r <= ~float_r;
  always_comb pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
    | (~pad_oe & ~ext_drv & (pad_pullup | float_r));
endmodule // pad_model

// ### testbench/testbench.sv
// self-checking bench for the port pin override logic
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0, ack, err, e;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q, ev, seed = 32'h00003F8B;
  logic [7:0] irq_en = 8'h00, ext_drv = 8'h00, ext_val = 8'h00, ana = 8'h00, stab;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, in_en, tap, ana_tap, dir_m, out_m;
  logic [1:0] ctl_m;
  logic ce = 1'b1;
  port_pin_pkg::override_t [7:0] ovr = '0, tmp;
  int fails = 0, cmp_count = 0, cyc_cnt = 0;

  always #12.5 clk_sys = ~clk_sys;

  port_pin_override_mux #(.WIDTH(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sleep_clamp(sleep),
    .ext_irq_en(irq_en), .ovr(ovr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .input_enable(in_en), .schmitt_tap_to_peripheral(tap),
    .analog_pad_line(ana), .analog_tap(ana_tap));
  pad_model #(.WIDTH(8)) pads (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_drv(ext_drv), .ext_val(ext_val), .pad_level(pad_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected {input enable, pull-up, driven level, driver enable}
  function automatic logic [31:0] exp_pins(input port_pin_pkg::override_t [7:0] o,
      input logic [7:0] d, input logic [7:0] p, input logic [1:0] c, input logic s,
      input logic [7:0] irq);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 8; i++) begin
      r[i] = o[i].dir_override_en ? o[i].dir_override_val : d[i];
      r[8+i] = r[i] & (o[i].value_override_en ? o[i].value_override_val : p[i]);
      r[16+i] = o[i].pullup_override_en ? o[i].pullup_override_val : (!d[i] && p[i] && !c[0]);
      r[24+i] = o[i].input_enable_override_en ? o[i].input_enable_override_val
        : (!(s | c[1]) | irq[i]);
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    if (n >= 50) fails++;
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt > 6000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    chk(32'(pad_pullup | pad_oe), 32'h0);
    rst_n <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'h1, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 4'h7, 32'h000000FF);
    chk(32'(e), 32'h1);
    $display("test reset and unmapped done");
    for (int k = 0; k < 40; k++) begin
      seed = xs(seed);
      wb(1'b1, 4'h0, seed);
      dir_m = seed[7:0];
      seed = xs(seed);
      wb(1'b1, 4'h1, seed);
      out_m = seed[7:0];
      seed = xs(seed);
      wb(1'b1, 4'h2, seed);
      out_m ^= seed[7:0];
      seed = xs(seed);
      wb(1'b1, 4'h3, seed);
      ctl_m = seed[1:0];
      for (int i = 0; i < 8; i++) begin
        seed = xs(seed);
        tmp[i] = seed[9] ? seed[8:0] : 9'h000;
        tmp[i].toggle_override_en = 1'b0;
      end
      seed = xs(seed);
      ev = exp_pins(tmp, dir_m, out_m, ctl_m, seed[0], seed[15:8]);
      ovr <= tmp;
      sleep <= seed[0];
      irq_en <= seed[15:8];
      ext_drv <= seed[23:16] & ~ev[7:0];
      ext_val <= seed[31:24];
      ana <= seed[7:0] ^ seed[31:24];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'(pad_oe), 32'(ev[7:0]));
      chk(32'(pad_out & pad_oe), 32'(ev[15:8]));
      chk(32'(pad_pullup), 32'(ev[23:16]));
      chk(32'(in_en), 32'(ev[31:24]));
      chk(32'(tap), 32'(pad_in & ev[31:24]));
      chk(32'(ana_tap), 32'(ana));
      stab = ev[7:0] | ext_drv | ev[23:16];
      wb(1'b0, 4'h2, 32'h0);
      chk(q & 32'(stab), 32'(pad_in & ev[31:24] & stab));
      wb(1'b0, 4'h1, 32'h0);
      chk(q, 32'(out_m));
    end
    $display("test random pins done");
    tmp = '0;
    tmp[3].toggle_override_en = 1'b1;
    @(posedge clk_sys);
    ovr <= tmp;
    @(posedge clk_sys);
    ovr <= '0;
    // clock enable low: toggle override must not move the output bit
    @(posedge clk_sys);
    ce <= 1'b0;
    ovr <= tmp;
    repeat (3) @(posedge clk_sys);
    ovr <= '0;
    ce <= 1'b1;
    sel <= 4'h0;
    wb(1'b1, 4'h1, ~32'(out_m));
    sel <= 4'hF;
    wb(1'b0, 4'h1, 32'h0);
    chk(q, 32'(out_m ^ 8'h08));
    $display("test toggle and byte select done");
    wb(1'b1, 4'h3, 32'h0);
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b1, 4'h1, 32'h000000FF);
    @(negedge clk_sys);
    chk(32'(pad_pullup), 32'h000000FF);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk(32'(pad_pullup), 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b0, 4'h1, 32'h0);
    chk(q, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule // testbench
